/* File: rtl/clk_div_pkg.sv */
// Shared constants for the output clock divider
package clk_div_pkg;
  localparam int         CNT_W            = 4;
  localparam int         CFG_W            = 8;
  localparam logic [7:0] FIRST_DIV_OFFSET = 8'h4a;
  localparam logic [7:0] LAST_DIV_OFFSET  = 8'h52;
  localparam int         OFF_SPAN_MSB     = 7;
  localparam int         OFF_SPAN_LSB     = 4;
  localparam int         ON_SPAN_MSB      = 3;
  localparam int         ON_SPAN_LSB      = 0;
  localparam logic [7:0] CFG_RESET        = 8'h00;
  localparam logic [3:0] CNT_ZERO         = 4'h0;
  localparam logic [3:0] CNT_ONE          = 4'h1;
endpackage : clk_div_pkg

/* File: rtl/span_counter.sv */
// Down counter that flags the last cycle of a programmed span
`timescale 1ns/1ps
`default_nettype none
module span_counter
  import clk_div_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clk_sys,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              last
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Reload on request, else count toward zero
  always_comb begin
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != W'(0)) begin
      cnt_nxt = cnt_r - W'(1);
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  // Register the count
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_r <= W'(0);
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign last = (cnt_r == W'(0));
endmodule : span_counter
`default_nettype wire

/* File: rtl/output_clock_divider_duty.sv */
// Programmable integer divider with high and low spans
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - Ratio equals (on+1) plus (off+1)
// R2 - Each span count is 4 bits, 0..15
// R3 - Divide by one only through bypass; bypass here only idles the divider and holds div_out low
// R4 - Duty equals (on+1) over total
// R5 - Off span bits 7:4, on span 3:0
// R6 - Same total, different split changes duty
// R7 - Both zero gives divide by two, 50%
// R8 - Divide by four offers 25/50/75%
// R9 - Counter alternates high then low spans
module output_clock_divider_duty
  import clk_div_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic             cfg_we,
  input  wire logic [CFG_W-1:0] cfg_wdata,
  input  wire logic             bypass,
  input  wire logic             sync_hold,
  input  wire logic             start_high,
  output logic      [CFG_W-1:0] cfg_rdata,
  output logic                  div_out,
  output logic                  div_active
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HIGH = 2'b01,
    ST_LOW  = 2'b11
  } phase_t;

  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_nxt;
  phase_t           st_r;
  phase_t           st_nxt;
  logic             out_r;
  logic             out_nxt;
  logic             act_r;
  logic             act_nxt;
  logic             load;
  logic [CNT_W-1:0] load_val;
  logic             span_last;
  logic [CNT_W-1:0] on_span_field;
  logic [CNT_W-1:0] off_span_field;

  // Field split of the configuration byte
  assign on_span_field  = cfg_r[ON_SPAN_MSB:ON_SPAN_LSB];   // [R5] [R2]
  assign off_span_field = cfg_r[OFF_SPAN_MSB:OFF_SPAN_LSB]; // [R5] [R2]

  // Configuration register write
  always_comb begin
    cfg_nxt = cfg_we ? cfg_wdata : cfg_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cfg_r <= CFG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // Phase sequencer: high span then low span, repeating until bypass or sync_hold forces idle
  always_comb begin
    st_nxt   = st_r;
    load     = 1'b0;
    load_val = on_span_field;
    case (st_r)
      ST_IDLE: begin
        if (!bypass && !sync_hold) begin
          st_nxt = ST_HIGH;
          load   = 1'b1;
        end
      end
      ST_HIGH: begin
        if (span_last) begin                 // [R9] [R1] [R4]
          st_nxt   = ST_LOW;
          load     = 1'b1;
          load_val = off_span_field;
        end
      end
      ST_LOW: begin
        if (span_last) begin                 // [R9] [R6] [R7] [R8]
          st_nxt   = ST_HIGH;
          load     = 1'b1;
          load_val = on_span_field;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    if (bypass || sync_hold) begin           // [R3]
      st_nxt = ST_IDLE;
      load   = 1'b0;
    end
  end

  // Output level and activity
  always_comb begin
    if (bypass || sync_hold) begin
      out_nxt = (sync_hold && !bypass) ? start_high : 1'b0; // [R3]
      act_nxt = 1'b0;
    end else begin
      out_nxt = (st_nxt == ST_HIGH);         // [R4]
      act_nxt = (st_nxt != ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_r      <= ST_IDLE;
      out_r     <= 1'b0;
      act_r     <= 1'b0;
      cfg_rdata <= CFG_RESET;
    end else begin
      st_r      <= st_nxt;
      out_r     <= out_nxt;
      act_r     <= act_nxt;
      cfg_rdata <= cfg_nxt;
    end
  end

  assign div_out    = out_r;
  assign div_active = act_r;

  span_counter #(.W(CNT_W)) u_span (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .load     (load),
    .load_val (load_val),
    .last     (span_last)
  );

  // Helper: length of the present active run of the output level
  // Quiet count guards against spans loaded from an older byte
  localparam logic [5:0] QUIET_MAX  = 6'h3f;
  localparam logic [5:0] QUIET_FULL = 6'h21;
  logic [5:0] run_r;
  logic [5:0] quiet_r;
  logic [5:0] hi_len_r;
  logic       out_d_r;
  logic       act_d_r;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      run_r    <= 6'h00;
      quiet_r  <= 6'h00;
      hi_len_r <= 6'h00;
      out_d_r  <= 1'b0;
      act_d_r  <= 1'b0;
    end else begin
      out_d_r  <= div_out;
      act_d_r  <= div_active;
      run_r    <= (div_out != out_d_r || !act_d_r) ? 6'h01 : run_r + 6'h01;
      quiet_r  <= cfg_we ? 6'h00 : ((quiet_r == QUIET_MAX) ? quiet_r : quiet_r + 6'h01);
      hi_len_r <= (out_d_r && !div_out) ? run_r : hi_len_r;
    end
  end

  // Span checks only once the running spans came from the present byte

  property p_high_len;
    @(posedge clk_sys) disable iff (!rstn)
      (act_d_r && div_active && $past(div_active) && out_d_r && !div_out && $past(act_d_r)
       && $stable(cfg_r)
       && quiet_r > run_r) |-> (run_r == 6'(on_span_field) + 6'h01);
  endproperty
  a_high_len: assert property (p_high_len) else $error("high span length wrong"); // [R4]

  property p_low_len;
    @(posedge clk_sys) disable iff (!rstn)
      (act_d_r && div_active && $past(div_active) && !out_d_r && div_out && $past(act_d_r)
       && $stable(cfg_r)
       && quiet_r > run_r) |-> (run_r == 6'(off_span_field) + 6'h01);
  endproperty
  a_low_len: assert property (p_low_len) else $error("low span length wrong"); // [R1]

  // Whole period equals the sum of both spans, whatever the split
  property p_period;
    @(posedge clk_sys) disable iff (!rstn)
      (act_d_r && div_active && $past(div_active) && !out_d_r && div_out && $past(act_d_r)
       && quiet_r > hi_len_r + run_r)
        |-> (hi_len_r + run_r == 6'(on_span_field) + 6'(off_span_field) + 6'h02);
  endproperty
  a_period: assert property (p_period) else $error("division ratio wrong"); // [R6]

  property p_bypass_idle;
    @(posedge clk_sys) disable iff (!rstn)
      bypass |=> (!div_active && !div_out);
  endproperty
  a_bypass_idle: assert property (p_bypass_idle) else $error("bypassed divider ran"); // [R3]

  property p_div2;
    @(posedge clk_sys) disable iff (!rstn)
      (cfg_r == CFG_RESET && div_active && div_out && !cfg_we && !bypass && !sync_hold
       && quiet_r >= QUIET_FULL)
        ##1 (!cfg_we && !bypass && !sync_hold) |-> !div_out;
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two broken"); // [R7]

  property p_start_high;
    @(posedge clk_sys) disable iff (!rstn)
      (st_r == ST_IDLE && !bypass && !sync_hold) |=> (div_out && st_r == ST_HIGH);
  endproperty
  a_start_high: assert property (p_start_high) else $error("run must open high"); // [R9]

  property p_readback;
    @(posedge clk_sys) disable iff (!rstn)
      cfg_we |=> (cfg_rdata == $past(cfg_wdata));
  endproperty
  a_readback: assert property (p_readback) else $error("config readback wrong"); // [R5]

  property p_div4_high;
    @(posedge clk_sys) disable iff (!rstn)
      (cfg_r == 8'h11 && st_r == ST_LOW && st_nxt == ST_HIGH && !cfg_we
       && !bypass && !sync_hold) ##1 (!cfg_we && !bypass && !sync_hold) |=> div_out;
  endproperty
  a_div4_high: assert property (p_div4_high) else $error("divide by four duty wrong"); // [R8]

  property p_hold_level;
    @(posedge clk_sys) disable iff (!rstn)
      (sync_hold && !bypass) |=> (div_out == $past(start_high));
  endproperty
  a_hold_level: assert property (p_hold_level) else $error("hold level wrong"); // [R9]
endmodule : output_clock_divider_duty
`default_nettype wire

/* File: sim/output_clock_divider_duty_test.sv */
// Self-checking bench for the output clock divider
`timescale 1ns/1ps
`default_nettype none
module output_clock_divider_duty_test;
  import clk_div_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rstn = 1'b0;
  logic             cfg_we = 1'b0;
  logic [CFG_W-1:0] cfg_wdata = 8'h00;
  logic             bypass = 1'b0;
  logic             sync_hold = 1'b0;
  logic             start_high = 1'b0;
  logic [CFG_W-1:0] cfg_rdata;
  logic             div_out;
  logic             div_active;
  int               mismatches = 0;
  int               n_compared = 0;
  int               hi_n;
  int               lo_n;
  logic [7:0]       cfgs [9] = '{8'h00, 8'h11, 8'h02, 8'h20, 8'h33, 8'h42, 8'hf0, 8'h0f, 8'hff};

  output_clock_divider_duty output_clock_divider_duty_i (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .cfg_we     (cfg_we),
    .cfg_wdata  (cfg_wdata),
    .bypass     (bypass),
    .sync_hold  (sync_hold),
    .start_high (start_high),
    .cfg_rdata  (cfg_rdata),
    .div_out    (div_out),
    .div_active (div_active)
  );

  // 250 MHz system clock
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  // Compare two bytes and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [7:0] d);
    @(posedge clk_sys);
    cfg_we    <= 1'b1;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_we    <= 1'b0;
  endtask : wr

  // Length of one high span and the following low span, bounded
  task automatic meas(output int h, output int l);
    int n;
    n = 0;
    h = 0;
    l = 0;
    while (div_out !== 1'b0 && n < 64) begin
      @(negedge clk_sys);
      n++;
    end
    while (div_out !== 1'b1 && n < 128) begin
      @(negedge clk_sys);
      n++;
    end
    while (div_out === 1'b1 && h < 40) begin
      @(negedge clk_sys);
      h++;
    end
    while (div_out === 1'b0 && l < 40) begin
      @(negedge clk_sys);
      l++;
    end
  endtask : meas

  // Program a byte, let old spans run out, then check spans
  task automatic run(input logic [7:0] d);
    wr(d);
    repeat (40) @(posedge clk_sys);
    chk(cfg_rdata, d);
    meas(hi_n, lo_n);
    chk(8'(hi_n), 8'(d[3:0]) + 8'h01);
    chk(8'(lo_n), 8'(d[7:4]) + 8'h01);
    $display("Test cfg %h done: high %0d low %0d", d, hi_n, lo_n);
  endtask : run

  // Verdict and end of run
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  // Watchdog against hangs
  initial begin
    #40000;
    mismatches++;
    stop_test();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    chk(cfg_rdata, CFG_RESET);
    for (int i = 0; i < 9; i++) begin
      run(cfgs[i]);
    end
    // Bypass stops the divider
    @(posedge clk_sys);
    bypass <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({6'h00, div_active, div_out}, 8'h00);
    @(posedge clk_sys);
    bypass <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({7'h00, div_active}, 8'h01);
    $display("Test bypass done");
    // Held divider shows start level
    @(posedge clk_sys);
    sync_hold  <= 1'b1;
    start_high <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk({7'h00, div_out}, 8'h01);
    @(posedge clk_sys);
    start_high <= 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({7'h00, div_out}, 8'h00);
    @(posedge clk_sys);
    sync_hold <= 1'b0;
    $display("Test hold done");
    run(8'h20);
    stop_test();
  end
endmodule : output_clock_divider_duty_test
`default_nettype wire
